// ### rtl/incoming_message_controller.sv
// receive-side message controller: port scan, handshake, message store
`timescale 1ns/100ps

// What this block does
// - a sequencer walks one message transfer and drives the parts other than the synchroniser, bit timer and processor access
// - each scanned port is watched for 40 us for request, cannot-accept or idle
// - reply stream carries idle, send, good ack or bad ack
// - incoming stream decodes idle, request, cannot-accept and data marker
// - bit counter gives bit position and fixes byte alignment of the input
// - the chosen reply byte is shifted out serially to the line
// - byte counter counts message bytes and is the buffer write address
// - each incoming byte is caught in an eight-bit latch
// - stored length equal to byte counter plus one marks the last byte
// - each byte but the last is added to the running sum of earlier bytes
// - last byte and sum are stored; equality gives checksum good
// - protocol faults of each stage are kept in an error kind register
// - buffer access is shared between byte counter writes and processor access
// - a port selector names the port being served
// - request means sender wants to send; send means receiver is ready
// - good ack reports success, bad ack reports failure
// - the data marker starts a data message
// - low idle fills quiet time; high idle asks for high priority only
// - line runs at 2.56 Mbps in logic-level form
// - buffer holds 256 eight-bit bytes; messages are up to 255 bytes long
// - up to 70 ports are scanned
// - checksum is validated and faults reported during the transfer
module incoming_message_controller
  import imc_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int DEPTH = BUF_BYTES
) (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       ARST_N,
  // serial link
  input  wire logic                       RX_DATA,
  output logic                            TX_DATA,
  output logic [$clog2(PORTS)-1:0]        PORT_SEL,
  input  wire logic                       HIGH_PRIORITY_ONLY,
  // processor access to the message buffer
  input  wire logic                       CPU_SEL,
  input  wire logic                       CPU_WE,
  input  wire logic [$clog2(DEPTH)-1:0]   CPU_ADDR,
  input  wire logic [7:0]                 CPU_WDATA,
  output logic [7:0]                      CPU_RDATA,
  output logic                            CPU_ACK,
  // message status
  output logic                            MSG_DONE,
  output logic [$clog2(DEPTH)-1:0]        MSG_LENGTH,
  output logic [2:0]                      ERROR_KIND,
  output logic                            ERROR_PULSE
);

  localparam int AW   = $clog2(DEPTH);
  localparam int PSW  = $clog2(PORTS);
  localparam int BTW  = $clog2(BIT_CYCLES);
  localparam int DWW  = $clog2(DWELL_CYCLES);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  seq_state_t       rx_sequencer;
  seq_state_t       next_state;
  error_kind_t      rx_error_kind_reg;
  logic             rx_meta;
  logic             rx_sync;
  logic [BTW-1:0]   bit_timer;
  logic             bit_strobe;
  logic [6:0]       rx_shift;
  logic [7:0]       rx_word;
  logic [2:0]       bit_position_counter;
  logic             hunt_hit;
  logic             rx_done;
  logic [7:0]       rx_byte_latch;
  logic             is_idle;
  logic             is_request;
  logic             is_cannot;
  logic             is_marker;
  logic [DWW-1:0]   scan_dwell_timer;
  logic             dwell_expired;
  logic [AW-1:0]    rx_length_reg;
  logic [AW-1:0]    rx_byte_counter;
  logic [7:0]       running_sum;
  logic [7:0]       check_byte;
  logic [7:0]       check_sum;
  logic             check_good;
  logic             last_byte;
  logic             reply_good;
  logic [7:0]       reply_code;
  logic [2:0]       tx_bit;
  logic [7:0]       tx_shift;
  logic             tx_load;
  logic             accept_request;
  logic             advance_port;
  logic             err_timeout;
  logic             err_sequence;
  logic             err_length;
  logic             err_overrun;
  logic             err_checksum;
  logic [7:0]       rx_message_buffer [DEPTH];

  byte_stream_if #(.WIDTH(AW + 8)) in_if ();
  byte_stream_if #(.WIDTH(AW + 8)) out_if ();

  // ----------------------------------------
  // input synchroniser and bit timing
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= RX_DATA;
      rx_sync <= rx_meta;
    end
  end

  // one strobe per line bit, shared by receiver and reply serializer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_timer <= '0;
    end else if (bit_strobe) begin
      bit_timer <= '0;
    end else begin
      bit_timer <= bit_timer + 1'b1;
    end
  end
  assign bit_strobe = (bit_timer == BTW'(BIT_CYCLES - 1));

  // ----------------------------------------
  // message decoder
  // ----------------------------------------
  assign rx_word    = {rx_shift, rx_sync};
  assign is_idle    = (rx_word == CODE_IN_IDLE);
  assign is_request = (rx_word == CODE_REQUEST);
  assign is_cannot  = (rx_word == CODE_CANNOT);
  assign is_marker  = (rx_word == CODE_MARKER);
  // while scanning, idle, request or cannot-accept re-fixes the byte boundary
  assign hunt_hit   = is_idle || is_request || is_cannot;
  assign rx_done    = bit_strobe && ((rx_sequencer == SEQ_SCAN) ? hunt_hit
                                     : (bit_position_counter == 3'd7));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_shift <= '1;
    end else if (bit_strobe) begin
      rx_shift <= rx_word[6:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_position_counter <= '0;
    end else if (rx_done) begin
      bit_position_counter <= '0;
    end else if (bit_strobe) begin
      bit_position_counter <= bit_position_counter + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_byte_latch <= RESET_BYTE;
    end else if (rx_done) begin
      rx_byte_latch <= rx_word;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign accept_request = (rx_sequencer == SEQ_SCAN) && rx_done && is_request;
  assign err_timeout    = (rx_sequencer == SEQ_AWAIT_MARKER) && dwell_expired && !rx_done;
  assign err_sequence   = (rx_sequencer == SEQ_AWAIT_MARKER) && rx_done
                          && !is_marker && !is_request;
  assign err_length     = (rx_sequencer == SEQ_GET_LENGTH) && rx_done
                          && (rx_word == RESET_BYTE);
  assign err_overrun    = (rx_sequencer == SEQ_GET_BYTES) && rx_done && !in_if.ready;
  assign err_checksum   = (rx_sequencer == SEQ_CHECK) && !check_good;
  assign advance_port   = ((rx_sequencer == SEQ_SCAN) && rx_done && !is_request)
                          || ((rx_sequencer == SEQ_SCAN) && dwell_expired && !rx_done)
                          || err_timeout
                          || ((rx_sequencer == SEQ_REPLY) && tx_load);

  always_comb begin
    next_state = rx_sequencer;
    case (rx_sequencer)
      SEQ_SCAN: begin
        if (accept_request) begin
          next_state = SEQ_AWAIT_MARKER;
        end
      end
      SEQ_AWAIT_MARKER: begin
        if (rx_done && is_marker) begin
          next_state = SEQ_GET_LENGTH;
        end else if (err_sequence) begin
          next_state = SEQ_REPLY;
        end else if (err_timeout) begin
          next_state = SEQ_SCAN;
        end
      end
      SEQ_GET_LENGTH: begin
        if (err_length) begin
          next_state = SEQ_REPLY;
        end else if (rx_done) begin
          next_state = SEQ_GET_BYTES;
        end
      end
      SEQ_GET_BYTES: begin
        if (err_overrun) begin
          next_state = SEQ_REPLY;
        end else if (rx_done && last_byte) begin
          next_state = SEQ_CHECK;
        end
      end
      SEQ_CHECK: begin
        next_state = SEQ_REPLY;
      end
      SEQ_REPLY: begin
        if (tx_load) begin
          next_state = SEQ_SCAN;
        end
      end
      default: begin
        next_state = SEQ_SCAN;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_sequencer <= SEQ_SCAN;
    end else begin
      rx_sequencer <= next_state;
    end
  end

  // ----------------------------------------
  // port selector and dwell timer
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PORT_SEL <= '0;
    end else if (advance_port) begin
      PORT_SEL <= (PORT_SEL == PSW'(PORTS - 1)) ? '0 : PORT_SEL + 1'b1;
    end
  end

  // reused while waiting for the marker so a peer repeating requests cannot hang the scan
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scan_dwell_timer <= DWW'(DWELL_CYCLES - 1);
    end else if (advance_port || accept_request) begin
      scan_dwell_timer <= DWW'(DWELL_CYCLES - 1);
    end else if (!dwell_expired) begin
      scan_dwell_timer <= scan_dwell_timer - 1'b1;
    end
  end
  assign dwell_expired = (scan_dwell_timer == '0);

  // ----------------------------------------
  // length, byte count and checksum
  // ----------------------------------------
  assign last_byte = (AW'(rx_byte_counter + 1'b1) == rx_length_reg);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_length_reg <= '0;
    end else if ((rx_sequencer == SEQ_GET_LENGTH) && rx_done) begin
      rx_length_reg <= rx_word[AW-1:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_byte_counter <= '0;
      running_sum     <= RESET_BYTE;
    end else if ((rx_sequencer == SEQ_GET_LENGTH) && rx_done) begin
      rx_byte_counter <= '0;
      running_sum     <= RESET_BYTE;
    end else if ((rx_sequencer == SEQ_GET_BYTES) && rx_done && in_if.ready && !last_byte) begin
      rx_byte_counter <= rx_byte_counter + 1'b1;
      running_sum     <= running_sum + rx_word;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      check_byte <= RESET_BYTE;
      check_sum  <= RESET_BYTE;
    end else if ((rx_sequencer == SEQ_GET_BYTES) && rx_done && in_if.ready && last_byte) begin
      check_byte <= rx_word;
      check_sum  <= running_sum;
    end
  end
  assign check_good = (check_byte == check_sum);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      reply_good <= 1'b0;
    end else if (rx_sequencer == SEQ_CHECK) begin
      reply_good <= check_good;
    end else if (accept_request || err_sequence || err_length || err_overrun) begin
      reply_good <= 1'b0;
    end
  end

  // ----------------------------------------
  // error kind register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_error_kind_reg <= ERR_NONE;
      ERROR_PULSE       <= 1'b0;
    end else begin
      ERROR_PULSE <= err_timeout || err_sequence || err_length || err_overrun
                     || err_checksum;
      if (err_timeout) begin
        rx_error_kind_reg <= ERR_TIMEOUT;
      end else if (err_sequence) begin
        rx_error_kind_reg <= ERR_SEQUENCE;
      end else if (err_length) begin
        rx_error_kind_reg <= ERR_LENGTH;
      end else if (err_overrun) begin
        rx_error_kind_reg <= ERR_OVERRUN;
      end else if (err_checksum) begin
        rx_error_kind_reg <= ERR_CHECKSUM;
      end else if (accept_request) begin
        rx_error_kind_reg <= ERR_NONE;
      end
    end
  end
  assign ERROR_KIND = rx_error_kind_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MSG_DONE   <= 1'b0;
      MSG_LENGTH <= '0;
    end else begin
      MSG_DONE <= (rx_sequencer == SEQ_REPLY) && tx_load && reply_good;
      if ((rx_sequencer == SEQ_REPLY) && tx_load && reply_good) begin
        MSG_LENGTH <= rx_length_reg;
      end
    end
  end

  // ----------------------------------------
  // reply select and serializer
  // ----------------------------------------
  always_comb begin
    case (rx_sequencer)
      SEQ_AWAIT_MARKER: reply_code = CODE_SEND;
      SEQ_REPLY:        reply_code = reply_good ? CODE_GOOD : CODE_BAD;
      default:          reply_code = HIGH_PRIORITY_ONLY ? CODE_IDLE_HI : CODE_IDLE_LO;
    endcase
  end

  assign tx_load = bit_strobe && (tx_bit == 3'd7);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_bit   <= '0;
      tx_shift <= CODE_IDLE_LO;
    end else if (bit_strobe) begin
      tx_bit <= tx_bit + 1'b1;
      if (tx_load) begin
        tx_shift <= reply_code;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end
  assign TX_DATA = tx_shift[7];

  // ----------------------------------------
  // byte path into the message buffer
  // ----------------------------------------
  // a byte arriving while the fifo is full is dropped and flagged as overrun
  assign in_if.valid = (rx_sequencer == SEQ_GET_BYTES) && rx_done;
  assign in_if.data  = {rx_byte_counter, rx_word};

  two_entry_buffer #(.WIDTH(AW + 8), .DEPTH(2)) byte_fifo (
    .clk    (CLK),
    .arst_n (ARST_N),
    .fill   (in_if),
    .drain  (out_if)
  );

  // processor wins the port; the fifo absorbs the stall
  assign out_if.ready = !CPU_SEL;

  always_ff @(posedge CLK) begin
    if (CPU_SEL && CPU_WE) begin
      rx_message_buffer[CPU_ADDR] <= CPU_WDATA;
    end else if (out_if.valid && out_if.ready) begin
      rx_message_buffer[out_if.data[AW+7:8]] <= out_if.data[7:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CPU_RDATA <= RESET_BYTE;
      CPU_ACK   <= 1'b0;
    end else begin
      CPU_ACK <= CPU_SEL;
      if (CPU_SEL && !CPU_WE) begin
        CPU_RDATA <= rx_message_buffer[CPU_ADDR];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence last_byte_seen;
    (rx_sequencer == SEQ_GET_BYTES) && rx_done && last_byte && in_if.ready;
  endsequence

  sequence check_then_reply;
    (rx_sequencer == SEQ_CHECK) ##1 (rx_sequencer == SEQ_REPLY);
  endsequence

  chk_last_byte_flow: assert property (last_byte_seen |=> check_then_reply)
    else $error("last byte did not lead to check and reply");

  chk_dwell_move: assert property ((rx_sequencer == SEQ_SCAN) && dwell_expired && !rx_done
    |=> PORT_SEL != $past(PORT_SEL) && scan_dwell_timer == DWW'(DWELL_CYCLES - 1))
    else $error("dwell expiry did not move to the next port");

  chk_port_range: assert property (PORT_SEL < PSW'(PORTS))
    else $error("port selector out of range");

  chk_ack_choice: assert property ((rx_sequencer == SEQ_CHECK)
    |=> reply_code == ($past(check_good) ? CODE_GOOD : CODE_BAD))
    else $error("acknowledge does not follow checksum");

  chk_count_step: assert property ((rx_sequencer == SEQ_GET_BYTES) && rx_done
    && in_if.ready && !last_byte |=> rx_byte_counter == AW'($past(rx_byte_counter) + 1'b1)
    && running_sum == 8'($past(running_sum) + $past(rx_word)))
    else $error("byte counter or running sum did not step");

  chk_bit_wrap: assert property ((rx_sequencer != SEQ_SCAN) && bit_strobe
    && (bit_position_counter == 3'd7) |-> rx_done ##1 bit_position_counter == 3'd0)
    else $error("bit position did not wrap at byte end");

  chk_tx_load: assert property (tx_load |=> TX_DATA == $past(reply_code[7]))
    else $error("reply byte not loaded into serializer");

  chk_overrun_kind: assert property (err_overrun
    |=> rx_error_kind_reg == ERR_OVERRUN && ERROR_PULSE ##1 rx_sequencer == SEQ_REPLY)
    else $error("overrun not recorded");

  chk_cpu_priority: assert property (CPU_SEL |-> !out_if.ready ##1 CPU_ACK)
    else $error("processor access not given priority");

endmodule // incoming_message_controller

// ### pkg/imc_pkg.sv
// shared constants and types of the incoming message controller
package imc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_FREQ_KHZ   = 100000;
  localparam int LINE_RATE_KBPS = 2560;
  // bit period rounds down so the sampler never lags the line
  localparam int BIT_CYCLES     = CLK_FREQ_KHZ / LINE_RATE_KBPS;
  localparam int DWELL_US       = 40;
  localparam int DWELL_CYCLES   = DWELL_US * CLK_FREQ_KHZ / 1000;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_PORTS = 70;
  localparam int BUF_BYTES = 256;

  // ----------------------------------------
  // message codes, incoming
  // ----------------------------------------
  localparam logic [7:0] CODE_IN_IDLE = 8'h7e;
  localparam logic [7:0] CODE_REQUEST = 8'h3c;
  localparam logic [7:0] CODE_CANNOT  = 8'h5a;
  localparam logic [7:0] CODE_MARKER  = 8'ha5;

  // ----------------------------------------
  // message codes, outgoing
  // ----------------------------------------
  localparam logic [7:0] CODE_IDLE_LO = 8'h7e;
  localparam logic [7:0] CODE_IDLE_HI = 8'h7d;
  localparam logic [7:0] CODE_SEND    = 8'h66;
  localparam logic [7:0] CODE_GOOD    = 8'h99;
  localparam logic [7:0] CODE_BAD     = 8'hc3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ERR_NONE, ERR_TIMEOUT, ERR_SEQUENCE, ERR_LENGTH, ERR_CHECKSUM, ERR_OVERRUN
  } error_kind_t;

  typedef enum {
    SEQ_SCAN, SEQ_AWAIT_MARKER, SEQ_GET_LENGTH, SEQ_GET_BYTES, SEQ_CHECK, SEQ_REPLY
  } seq_state_t;

endpackage

// ### pkg/byte_stream_if.sv
// valid/ready stream carrying an address and a byte
`timescale 1ns/100ps
interface byte_stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### rtl/two_entry_buffer.sv
// small fifo between the receiver and the message buffer write port
`timescale 1ns/100ps
module two_entry_buffer
  import imc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic   clk,
  input wire logic   arst_n,
  // streams
  byte_stream_if.snk fill,
  byte_stream_if.src drain
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      fill_count;
  logic             push;
  logic             pop;

  assign fill.ready  = (fill_count != (PW+1)'(DEPTH));
  assign drain.valid = (fill_count != '0);
  assign drain.data  = slot[rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_count <= '0;
    end else if (push && !pop) begin
      fill_count <= fill_count + 1'b1;
    end else if (pop && !push) begin
      fill_count <= fill_count - 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_fill_bound: assert property (@(posedge clk) disable iff (!arst_n)
    fill_count <= (PW+1)'(DEPTH))
    else $error("buffer holds more than its depth");

  chk_fill_step: assert property (@(posedge clk) disable iff (!arst_n)
    push && !pop |=> fill_count == $past(fill_count) + 1'b1)
    else $error("buffer count missed a push");

endmodule // two_entry_buffer

// ### verification/peripheral_model.sv
// peripheral model: serial bytes into the controller
`timescale 1ns/100ps
module peripheral_model
  import imc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // serial line
  output logic      line
);
  logic [7:0] q[$];
  logic [7:0] sh;
  logic [7:0] cur;
  int         cyc;
  int         nbit;
  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask
  // edges sit mid-bit so each bit is stable across the strobe
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc  <= 0;
      nbit <= 0;
      line <= 1'h0;
    end else begin
      cyc <= cyc + 1;
      if (cyc % BIT_CYCLES == BIT_CYCLES / 2) begin
        // quiet time is low idle, never a stale byte
        cur = nbit != 0 ? sh : q.size() != 0 ? q.pop_front() : CODE_IN_IDLE;
        line <= cur[7];
        sh   <= {cur[6:0], 1'h0};
        nbit <= (nbit + 1) % 8;
      end
    end
  end
endmodule // peripheral_model

// ### verification/incoming_message_controller_bench.sv
// self-checking bench for the incoming message controller
`timescale 1ns/100ps
module incoming_message_controller_bench;
  import imc_pkg::*;
  logic        clk = 1'h0;
  logic        arst_n = 1'h0;
  logic        rx;
  logic        tx;
  logic        hi_pri = 1'h0;
  logic        sel = 1'h0;
  logic        we = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        ack;
  logic        done;
  logic [7:0]  len_out;
  logic [2:0]  kind;
  logic        err;
  logic [6:0]  port;
  logic [7:0]  txw = 8'h00;
  logic [31:0] seed = 32'h3bc63d42;
  bit          seen [256];
  int          cyc;
  int          num_errors;
  int          num_checks;
  always #5 clk = ~clk;
  peripheral_model peer (.clk(clk), .arst_n(arst_n), .line(rx));
  incoming_message_controller dut (.CLK(clk), .ARST_N(arst_n), .RX_DATA(rx), .TX_DATA(tx),
    .PORT_SEL(port), .HIGH_PRIORITY_ONLY(hi_pri), .CPU_SEL(sel), .CPU_WE(we),
    .CPU_ADDR(addr), .CPU_WDATA(wdata), .CPU_RDATA(rdata), .CPU_ACK(ack),
    .MSG_DONE(done), .MSG_LENGTH(len_out), .ERROR_KIND(kind), .ERROR_PULSE(err));
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cpu(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clk);
    sel   <= 1'h1;
    we    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    sel <= 1'h0;
    #1;
    check(8'(ack), 8'h01);
    r = rdata;
  endtask
  task automatic run_msg(input logic [7:0] mark, input int len, input logic [7:0] flip,
                         input logic [2:0] exp);
    logic [7:0] m[$];
    logic [7:0] sum;
    logic [7:0] r;
    int         w;
    sum = 8'h00;
    for (int i = 1; i < len; i++) begin
      m.push_back(rnd());
      sum += m[$];
    end
    m.push_back(sum ^ flip);
    seen = '{default: 0};
    peer.put(CODE_REQUEST);
    peer.put(mark);
    if (mark == CODE_MARKER) begin
      peer.put(len[7:0]);
      for (int i = 0; i < len; i++) peer.put(m[i]);
    end
    w = 0;
    while (done !== 1'h1 && err !== 1'h1 && w < 20000) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(8'(w < 20000), 8'h01);
    check(8'(kind), 8'(exp));
    check(8'(done), 8'(exp == ERR_NONE));
    if (exp == ERR_NONE) begin
      check(len_out, len[7:0]);
      for (int i = 0; i < len; i++) begin
        cpu(1'h0, i[7:0], 8'h00, r);
        check(r, m[i]);
      end
    end
    repeat (700) @(posedge clk);
    check(8'(seen[(exp == ERR_NONE) ? CODE_GOOD : CODE_BAD]), 8'h01);
    check(8'(seen[CODE_SEND]), 8'h01);
    check(8'(port < 7'd70), 8'h01);
  endtask
  // sliding window on the reply line, phase free of the strobe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % BIT_CYCLES == 0) begin
      txw = {txw[6:0], tx};
      seen[txw] = 1'b1;
    end
    if (cyc == 95000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] d;
    logic [7:0] r;
    logic [6:0] p;
    int         w;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    peer.put(CODE_CANNOT);
    run_msg(CODE_MARKER, 1, 8'h00, ERR_NONE);
    for (int n = 0; n < 3; n++) run_msg(CODE_MARKER, 2 + rnd() % 8, 8'h00, ERR_NONE);
    run_msg(CODE_MARKER, 6, 8'h10, ERR_CHECKSUM);
    run_msg(CODE_MARKER, 0, 8'h00, ERR_LENGTH);
    run_msg(8'h00, 0, 8'h00, ERR_SEQUENCE);
    // processor holds the port so the fifo fills and the last byte overruns
    sel <= 1'h1;
    we  <= 1'h0;
    run_msg(CODE_MARKER, 3, 8'h00, ERR_OVERRUN);
    sel <= 1'h0;
    d = rnd();
    cpu(1'h1, 8'hf0, d, r);
    cpu(1'h0, 8'hf0, 8'h00, r);
    check(r, d);
    // repeated requests and no marker outlast the dwell
    repeat (13) peer.put(CODE_REQUEST);
    w = 0;
    while (err !== 1'h1 && w < 20000) begin
      @(posedge clk);
      #1;
      w++;
    end
    check(8'(w < 20000), 8'h01);
    check(8'(kind), 8'(ERR_TIMEOUT));
    // a silent line in scan must move on after the dwell
    repeat (300) @(posedge clk);
    repeat (16) peer.put(8'h00);
    repeat (700) @(posedge clk);
    p = port;
    repeat (4100) @(posedge clk);
    check(8'(port != p), 8'h01);
    @(posedge clk);
    hi_pri <= 1'h1;
    seen = '{default: 0};
    repeat (1500) @(posedge clk);
    check(8'(seen[CODE_IDLE_HI]), 8'h01);
    print_verdict();
  end
endmodule // incoming_message_controller_bench
